// [core/hpf_host_port.sv]
`timescale 1ns/1ps
`include "hpf_defines.svh"

module hpf_host_port #(
  parameter int unsigned STRETCH_CYC = `HPF_STRETCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic rom_read_strobe_n,
  input wire logic address_qualifier,
  input wire logic [15:4] upper_io_address_bits,
  input wire logic [15:0] io_data_in,
  output logic [15:0] io_data_out,
  output logic io_data_oe,
  output logic wide_io_ack_n_out,
  output logic wide_io_ack_n_oe,
  output logic rom_select_n,
  input wire logic irq_request,
  output logic [3:0] irq_out,
  output logic [3:0] irq_oe,
  output logic serial_mem_clock,
  output logic serial_mem_select,
  output logic serial_mem_out,
  input wire logic serial_mem_in,
  input wire logic [1:0] config_switch_low_pair,
  input wire logic config_switch_high,
  input wire logic external_codec_strap_n,
  input wire logic wide_bus_strap_n,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic link_ok,
  input wire logic nrz_tx_data,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  input wire logic bsel_pin_in,
  output logic bsel_pin_out,
  output logic bsel_pin_oe,
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe,
  input wire logic link_pin_in,
  output logic link_pin_out,
  output logic link_pin_oe,
  output logic nrz_rx_data,
  output logic nrz_receive_clock,
  output logic external_codec
);
  hpf_serial_if sif ();

  logic [1:0] interrupt_line_select_reg;
  logic wide_prog_reg;
  logic [15:0] base_reg;
  logic [15:0] host_rdata_reg;
  logic [15:0] host_wdata_reg;
  logic [3:0] host_waddr_reg;
  logic host_new_reg;
  logic [4:0] ser_last_reg;
  logic [31:0] ser_tx_reg;
  logic ser_start_reg;
  logic ser_done_reg;
  logic strap_taken_reg;
  logic ext_codec_reg;
  logic wide_strap_reg;
  logic wr_strobe_d_reg;
  logic wr_hit_d_reg;
  logic [31:0] stretch_cnt_reg [3];
  logic [2:0] stretch_on;
  logic [2:0] stretch_trig;
  logic apb_done;
  logic apb_wr;
  logic [7:0] apb_ofs;
  logic ofs_ok;
  logic io_hit;
  logic wide_mode;
  logic [31:0] rd_mux;

  // ==========================================================
  // straps and decode
  assign wide_mode = !wide_strap_reg || wide_prog_reg;
  assign io_hit = !address_qualifier && (upper_io_address_bits == base_reg[15:4]);

  // straps caught once after reset release, so reset takes constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken_reg <= 1'b0;
      ext_codec_reg <= 1'b0;
      wide_strap_reg <= 1'b1;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      ext_codec_reg <= !external_codec_strap_n;
      wide_strap_reg <= wide_bus_strap_n;
    end
  end

  // ==========================================================
  // apb slave: one wait state, read data registered with pready
  assign apb_done = psel && penable && pready;
  assign apb_wr = apb_done && pwrite && ofs_ok; // refused offsets never write
  assign apb_ofs = paddr[7:0];
  assign ofs_ok = (paddr[31:8] == 24'h000000) && (apb_ofs[1:0] == 2'b00)
    && (apb_ofs <= `HPF_OFS_STRAPS);

  // read mux over the register map
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (apb_ofs)
      `HPF_OFS_CONFIG: rd_mux = {29'h0, wide_prog_reg, interrupt_line_select_reg};
      `HPF_OFS_BASE: rd_mux = {16'h0000, base_reg};
      `HPF_OFS_HOST_RDATA: rd_mux = {16'h0000, host_rdata_reg};
      `HPF_OFS_HOST_WDATA: rd_mux = {host_new_reg, 11'h000, host_waddr_reg, host_wdata_reg};
      `HPF_OFS_SER_CTRL: rd_mux = {27'h0, ser_last_reg};
      `HPF_OFS_SER_TXDATA: rd_mux = ser_tx_reg;
      `HPF_OFS_SER_STATUS: rd_mux = {30'h0, ser_done_reg, sif.busy};
      `HPF_OFS_SER_RXDATA: rd_mux = sif.rx_data;
      `HPF_OFS_STRAPS: rd_mux = {27'h0, wide_mode, ext_codec_reg,
        config_switch_high, config_switch_low_pair};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // handshake and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !ofs_ok;
      if (psel && penable && !pready && !pwrite && ofs_ok) begin
        prdata <= rd_mux;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wide_prog_reg, interrupt_line_select_reg} <= `HPF_CONFIG_RESET;
      base_reg <= `HPF_BASE_RESET;
      host_rdata_reg <= 16'h0000;
      ser_last_reg <= 5'h00;
      ser_tx_reg <= 32'h0000_0000;
    end else if (apb_wr) begin
      if (apb_ofs == `HPF_OFS_CONFIG) begin
        interrupt_line_select_reg <= pwdata[1:0];
        wide_prog_reg <= pwdata[`HPF_CFG_WIDE_BIT];
      end
      if (apb_ofs == `HPF_OFS_BASE) begin
        base_reg <= pwdata[15:0];
      end
      if (apb_ofs == `HPF_OFS_HOST_RDATA) begin
        host_rdata_reg <= pwdata[15:0];
      end
      if (apb_ofs == `HPF_OFS_SER_CTRL && !sif.busy) begin
        ser_last_reg <= pwdata[4:0];
      end
      if (apb_ofs == `HPF_OFS_SER_TXDATA && !sif.busy) begin
        ser_tx_reg <= pwdata;
      end
    end
  end

  // serial start pulse; a start while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_start_reg <= 1'b0;
      ser_done_reg <= 1'b0;
    end else begin
      ser_start_reg <= apb_wr && (apb_ofs == `HPF_OFS_SER_CTRL)
        && pwdata[`HPF_SER_START_BIT] && !sif.busy && !ser_start_reg;
      // done is sticky; set wins over a write-one clear
      if (sif.done) begin
        ser_done_reg <= 1'b1;
      end else if (apb_wr && apb_ofs == `HPF_OFS_SER_STATUS && pwdata[1]) begin
        ser_done_reg <= 1'b0;
      end
    end
  end

  assign sif.start = ser_start_reg;
  assign sif.last_bit = ser_last_reg;
  assign sif.tx_data = ser_tx_reg;
  assign sif.mem_in = serial_mem_in;

  hpf_serial_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  assign serial_mem_clock = sif.mem_clock;
  assign serial_mem_select = sif.mem_select;
  assign serial_mem_out = sif.mem_out;

  // ==========================================================
  // host local bus side
  // read data driven while the strobe is low and decoded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_data_out <= 16'h0000;
      io_data_oe <= 1'b0;
    end else begin
      io_data_out <= host_rdata_reg;
      io_data_oe <= !io_read_strobe_n && io_hit;
    end
  end

  // write data captured every cycle the strobe is low and decoded; new flag set at the strobe's rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_strobe_d_reg <= 1'b0;
      wr_hit_d_reg <= 1'b0;
      host_wdata_reg <= 16'h0000;
      host_waddr_reg <= 4'h0;
      host_new_reg <= 1'b0;
    end else begin
      wr_strobe_d_reg <= !io_write_strobe_n;
      wr_hit_d_reg <= !io_write_strobe_n && io_hit;
      if (!io_write_strobe_n && io_hit) begin
        host_wdata_reg <= io_data_in;
        host_waddr_reg <= upper_io_address_bits[7:4];
      end
      // new-data flag: set wins over the software clear
      if (wr_strobe_d_reg && io_write_strobe_n && wr_hit_d_reg) begin
        host_new_reg <= 1'b1;
      end else if (apb_wr && apb_ofs == `HPF_OFS_HOST_WDATA && pwdata[`HPF_HWD_NEW_BIT]) begin
        host_new_reg <= 1'b0;
      end
    end
  end

  // wide ack, rom select and interrupt routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_io_ack_n_out <= 1'b0;
      wide_io_ack_n_oe <= 1'b0;
      rom_select_n <= 1'b1;
      irq_out <= 4'h0;
      irq_oe <= 4'h0;
    end else begin
      wide_io_ack_n_oe <= wide_mode && io_hit;
      rom_select_n <= rom_read_strobe_n || address_qualifier;
      for (int i = 0; i < 4; i++) begin
        irq_out[i] <= irq_request && (interrupt_line_select_reg == 2'(i));
        irq_oe[i] <= (interrupt_line_select_reg == 2'(i));
      end
    end
  end

  // ==========================================================
  // indicator stretch, one retriggerable timer per channel
  assign stretch_trig[hpf_pkg::HPF_CH_BSEL] = io_hit
    && (!io_read_strobe_n || !io_write_strobe_n);
  assign stretch_trig[hpf_pkg::HPF_CH_TX] = tx_active;
  assign stretch_trig[hpf_pkg::HPF_CH_RX] = rx_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 3; c++) begin
        stretch_cnt_reg[c] <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (stretch_trig[c]) begin
          stretch_cnt_reg[c] <= STRETCH_CYC;
        end else if (stretch_cnt_reg[c] != 32'h0000_0000) begin
          stretch_cnt_reg[c] <= stretch_cnt_reg[c] - 32'h0000_0001;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      stretch_on[c] = stretch_trig[c] || (stretch_cnt_reg[c] != 32'h0000_0000);
    end
  end

  // ==========================================================
  // dual-function pins; the link pin is a level, never stretched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_out <= 1'b0;
      tx_pin_oe <= 1'b0;
      bsel_pin_out <= 1'b0;
      bsel_pin_oe <= 1'b0;
      rx_pin_out <= 1'b0;
      rx_pin_oe <= 1'b0;
      link_pin_out <= 1'b0;
      link_pin_oe <= 1'b0;
      nrz_rx_data <= 1'b0;
      nrz_receive_clock <= 1'b0;
      external_codec <= 1'b0;
    end else begin
      external_codec <= ext_codec_reg;
      if (ext_codec_reg) begin
        tx_pin_out <= !tx_active;
        tx_pin_oe <= 1'b1;
        bsel_pin_out <= 1'b0;
        bsel_pin_oe <= 1'b0;
        nrz_rx_data <= bsel_pin_in;
        rx_pin_out <= 1'b0;
        rx_pin_oe <= 1'b0;
        nrz_receive_clock <= rx_pin_in;
        link_pin_out <= nrz_tx_data;
        link_pin_oe <= 1'b1;
      end else begin
        // open drain: pull low to light, release otherwise
        tx_pin_out <= 1'b0;
        tx_pin_oe <= stretch_on[hpf_pkg::HPF_CH_TX];
        bsel_pin_out <= 1'b0;
        bsel_pin_oe <= stretch_on[hpf_pkg::HPF_CH_BSEL];
        nrz_rx_data <= 1'b0;
        rx_pin_out <= 1'b0;
        rx_pin_oe <= stretch_on[hpf_pkg::HPF_CH_RX];
        nrz_receive_clock <= 1'b0;
        link_pin_out <= 1'b0;
        link_pin_oe <= link_ok;
      end
    end
  end
endmodule // hpf_host_port

// [core/hpf_defines.svh]
`ifndef HPF_DEFINES_SVH
`define HPF_DEFINES_SVH

// ==========================================================
// apb register byte offsets
`define HPF_OFS_CONFIG 8'h00
`define HPF_OFS_BASE 8'h04
`define HPF_OFS_HOST_RDATA 8'h08
`define HPF_OFS_HOST_WDATA 8'h0c
`define HPF_OFS_SER_CTRL 8'h10
`define HPF_OFS_SER_TXDATA 8'h14
`define HPF_OFS_SER_STATUS 8'h18
`define HPF_OFS_SER_RXDATA 8'h1c
`define HPF_OFS_STRAPS 8'h20

// ==========================================================
// field positions
`define HPF_CFG_WIDE_BIT 2
`define HPF_HWD_NEW_BIT 31
`define HPF_SER_START_BIT 31
`define HPF_STR_EXT_BIT 3
`define HPF_STR_WIDE_BIT 4

// ==========================================================
// reset values
`define HPF_BASE_RESET 16'h0300
`define HPF_CONFIG_RESET 3'h0

// ==========================================================
// timing: system clock, serial memory clock and indicator stretch
`define HPF_CLK_NS 10
`define HPF_SER_PERIOD_NS 4000
`define HPF_SER_HALF_CYC (`HPF_SER_PERIOD_NS / (2 * `HPF_CLK_NS))
`define HPF_STRETCH_MS 20
`define HPF_STRETCH_CYC (`HPF_STRETCH_MS * 1000000 / `HPF_CLK_NS)

`endif

// [core/hpf_pkg.sv]
package hpf_pkg;
  // serial memory shifter states, gray along idle-select-shift-done
  typedef enum logic [1:0] {
    HPF_SER_IDLE = 2'b00,
    HPF_SER_SELECT = 2'b01,
    HPF_SER_SHIFT = 2'b11,
    HPF_SER_DONE = 2'b10
  } hpf_ser_state_t;

  // indicator stretch channels
  typedef enum logic [1:0] {
    HPF_CH_BSEL = 2'd0,
    HPF_CH_TX = 2'd1,
    HPF_CH_RX = 2'd2
  } hpf_stretch_ch_t;
endpackage

// [core/hpf_serial_if.sv]
`timescale 1ns/1ps
// ==========================================================
// control and pin group between register file and shifter
interface hpf_serial_if;
  logic start;
  logic [4:0] last_bit;
  logic [31:0] tx_data;
  logic busy;
  logic done;
  logic [31:0] rx_data;
  logic mem_clock;
  logic mem_select;
  logic mem_out;
  logic mem_in;

  modport ctrl (
    output start, last_bit, tx_data, mem_in,
    input busy, done, rx_data, mem_clock, mem_select, mem_out
  );
  modport shifter (
    input start, last_bit, tx_data, mem_in,
    output busy, done, rx_data, mem_clock, mem_select, mem_out
  );
endinterface // hpf_serial_if

// [core/hpf_serial_shift.sv]
`timescale 1ns/1ps
`include "hpf_defines.svh"

// ==========================================================
// serial configuration memory shifter
module hpf_serial_shift (
  input wire logic pclk,
  input wire logic presetn,
  hpf_serial_if.shifter sif
);
  localparam logic [7:0] HALF = 8'(`HPF_SER_HALF_CYC);

  hpf_pkg::hpf_ser_state_t state_reg;
  logic [7:0] half_cnt_reg;
  logic [4:0] bit_reg;
  logic [31:0] sh_out_reg;
  logic [31:0] sh_in_reg;
  logic half_end;

  assign half_end = (half_cnt_reg == HALF - 8'h01);

  // half-period timer, restarts on every phase change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_reg <= 8'h00;
    end else if (state_reg == hpf_pkg::HPF_SER_IDLE || half_end) begin
      half_cnt_reg <= 8'h00;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // sequence: select for a half period, shift, hold select off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= hpf_pkg::HPF_SER_IDLE;
      bit_reg <= 5'h00;
      sif.mem_clock <= 1'b0;
      sif.mem_select <= 1'b0;
    end else begin
      unique case (state_reg)
        hpf_pkg::HPF_SER_IDLE: begin
          if (sif.start) begin
            state_reg <= hpf_pkg::HPF_SER_SELECT;
            sif.mem_select <= 1'b1;
            bit_reg <= 5'h00;
          end
        end
        hpf_pkg::HPF_SER_SELECT: begin
          if (half_end) begin
            state_reg <= hpf_pkg::HPF_SER_SHIFT;
          end
        end
        hpf_pkg::HPF_SER_SHIFT: begin
          // one clock period is two half periods: 4 us total
          if (half_end) begin
            sif.mem_clock <= ~sif.mem_clock;
            if (sif.mem_clock) begin
              if (bit_reg == sif.last_bit) begin
                state_reg <= hpf_pkg::HPF_SER_DONE;
              end
              bit_reg <= bit_reg + 5'h01;
            end
          end
        end
        hpf_pkg::HPF_SER_DONE: begin
          if (half_end) begin
            state_reg <= hpf_pkg::HPF_SER_IDLE;
            sif.mem_select <= 1'b0;
          end
        end
      endcase
    end
  end

  // output data changes while the clock is low, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_out_reg <= 32'h0000_0000;
      sif.mem_out <= 1'b0;
    end else if (state_reg == hpf_pkg::HPF_SER_IDLE && sif.start) begin
      sh_out_reg <= sif.tx_data << (5'd31 - sif.last_bit);
    end else if (state_reg == hpf_pkg::HPF_SER_SELECT && half_end) begin
      sif.mem_out <= sh_out_reg[31];
      sh_out_reg <= {sh_out_reg[30:0], 1'b0};
    end else if (state_reg == hpf_pkg::HPF_SER_SHIFT && half_end && sif.mem_clock) begin
      sif.mem_out <= sh_out_reg[31];
      sh_out_reg <= {sh_out_reg[30:0], 1'b0};
    end
  end

  // input sampled on the rising serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_in_reg <= 32'h0000_0000;
    end else if (state_reg == hpf_pkg::HPF_SER_IDLE && sif.start) begin
      sh_in_reg <= 32'h0000_0000;
    end else if (state_reg == hpf_pkg::HPF_SER_SHIFT && half_end && !sif.mem_clock) begin
      sh_in_reg <= {sh_in_reg[30:0], sif.mem_in};
    end
  end

  // status back to the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.busy <= 1'b0;
      sif.done <= 1'b0;
      sif.rx_data <= 32'h0000_0000;
    end else begin
      sif.busy <= (state_reg != hpf_pkg::HPF_SER_IDLE) || sif.start;
      sif.done <= (state_reg == hpf_pkg::HPF_SER_DONE) && half_end;
      if (state_reg == hpf_pkg::HPF_SER_DONE && half_end) begin
        sif.rx_data <= sh_in_reg;
      end
    end
  end
endmodule // hpf_serial_shift

// [verif/hpf_host_port_asserts.sv]
`timescale 1ns/1ps
`include "hpf_defines.svh"
// ==========================================================
// port checks of the host port block
module hpf_port_chk #(
  parameter int unsigned STRETCH_CYC = `HPF_STRETCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic rom_read_strobe_n,
  input wire logic address_qualifier,
  input wire logic io_data_oe,
  input wire logic wide_io_ack_n_out,
  input wire logic wide_io_ack_n_oe,
  input wire logic rom_select_n,
  input wire logic irq_request,
  input wire logic [3:0] irq_out,
  input wire logic [3:0] irq_oe,
  input wire logic serial_mem_clock,
  input wire logic serial_mem_select,
  input wire logic bsel_pin_oe,
  input wire logic rx_pin_oe,
  input wire logic link_pin_oe,
  input wire logic link_pin_out,
  input wire logic nrz_tx_data,
  input wire logic external_codec
);
  localparam int HALF = `HPF_SER_HALF_CYC; // serial clock half period in pclk cycles
  logic [15:0] run_cnt;
  logic lead;
  logic [31:0] idle_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since last serial pin change; saturates so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_cnt <= 16'h0;
    else if ($changed(serial_mem_clock) || $changed(serial_mem_select)) run_cnt <= 16'h1;
    else if (run_cnt != 16'hffff) run_cnt <= run_cnt + 16'h1;
  end
  // first rise waits a select half plus a data setup half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lead <= 1'b0;
    else if ($rose(serial_mem_select)) lead <= 1'b1;
    else if ($changed(serial_mem_clock)) lead <= 1'b0;
  end
  // cycles since the last host strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt <= 32'h0;
    else if (!io_read_strobe_n || !io_write_strobe_n) idle_cnt <= 32'h0;
    else if (idle_cnt != 32'hffffffff) idle_cnt <= idle_cnt + 32'h1;
  end
  AST_IRQ_ONE: assert property ($countones(irq_oe) <= 1)
    else $error("two interrupt lines driven");
  AST_IRQ_SRC: assert property (irq_out != 4'h0 |-> $past(irq_request))
    else $error("interrupt without request");
  AST_WIDE_LOW: assert property (wide_io_ack_n_out == 1'b0)
    else $error("wide ack drives high");
  AST_WIDE_QUAL: assert property (wide_io_ack_n_oe |-> $past(!address_qualifier))
    else $error("wide ack with qualifier high");
  AST_RD_OE: assert property (io_data_oe |-> $past(!io_read_strobe_n && !address_qualifier))
    else $error("data driven without read");
  AST_ROM: assert property (!rom_select_n |-> $past(!rom_read_strobe_n && !address_qualifier))
    else $error("rom select without strobe");
  AST_SER_FRAME: assert property (serial_mem_clock |-> serial_mem_select)
    else $error("serial clock outside select");
  AST_SER_HALF: assert property ((($changed(serial_mem_clock) && !lead)
    || $fell(serial_mem_select)) |-> run_cnt == HALF)
    else $error("serial half period wrong");
  AST_SER_LEAD: assert property ($changed(serial_mem_clock) && lead
    |-> run_cnt == 2 * HALF)
    else $error("serial first rise late or early");
  AST_STRETCH: assert property (idle_cnt > STRETCH_CYC + 4 |-> !bsel_pin_oe)
    else $error("board select stays lit");
  AST_HOLD: assert property ($fell(io_data_oe) && !external_codec |-> bsel_pin_oe [*8])
    else $error("board select not stretched");
  AST_EXT_IN: assert property ($past(external_codec) && external_codec
    |-> !bsel_pin_oe && !rx_pin_oe)
    else $error("input pin driven in external mode");
  AST_EXT_TXD: assert property ($past(external_codec) && external_codec
    |-> link_pin_oe && link_pin_out == $past(nrz_tx_data))
    else $error("transmit data pin wrong");
  cover property ($fell(serial_mem_select));
  cover property ($fell(io_data_oe) && !external_codec);
  cover property (wide_io_ack_n_oe);
endmodule // hpf_port_chk

bind hpf_host_port hpf_port_chk #(.STRETCH_CYC(STRETCH_CYC)) u_chk (.*);

// [verif/hpf_mem_model.sv]
`timescale 1ns/1ps
// ==========================================================
// serial configuration memory, msb first, pulled low when idle
module hpf_mem_model #(
  parameter logic [7:0] REPLY = 8'ha5
) (
  input wire logic pclk,
  input wire logic clock,
  input wire logic select,
  input wire logic din,
  output logic dout,
  output logic [7:0] seen
);
  logic clk_q;
  logic [7:0] rep;
  // shift on clock fall so data is steady at the next rise
  always_ff @(posedge pclk) begin
    clk_q <= clock;
    if (!select) rep <= REPLY;
    else if (clk_q && !clock) rep <= {rep[6:0], 1'b0};
    if (!clk_q && clock) seen <= {seen[6:0], din};
  end
  assign dout = select ? rep[7] : 1'b0;
endmodule // hpf_mem_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// bench for the host port block
module tb_top;
  localparam int unsigned STR = 20;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err, b;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic io_read_strobe_n, io_write_strobe_n, rom_read_strobe_n, address_qualifier;
  logic [15:4] upper_io_address_bits;
  logic [15:0] io_data_in, io_data_out;
  logic io_data_oe, wide_io_ack_n_out, wide_io_ack_n_oe, rom_select_n, irq_request;
  logic [3:0] irq_out, irq_oe;
  logic serial_mem_clock, serial_mem_select, serial_mem_out, serial_mem_in;
  logic [1:0] config_switch_low_pair;
  logic config_switch_high, external_codec_strap_n, wide_bus_strap_n;
  logic tx_active, rx_active, link_ok, nrz_tx_data, codec_rxd, codec_nrz_receive_clock;
  logic tx_pin_in, tx_pin_out, tx_pin_oe, bsel_pin_in, bsel_pin_out, bsel_pin_oe;
  logic rx_pin_in, rx_pin_out, rx_pin_oe, link_pin_in, link_pin_out, link_pin_oe;
  logic nrz_rx_data, nrz_receive_clock, external_codec;
  logic [7:0] mem_seen;
  int error_cnt = 0;
  int cmp_count = 0;
  // pins with pull-ups; the codec drives when the block lets go
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
  assign link_pin_in = link_pin_oe ? link_pin_out : 1'b1;
  assign bsel_pin_in = bsel_pin_oe ? bsel_pin_out : codec_rxd;
  assign rx_pin_in = rx_pin_oe ? rx_pin_out : codec_nrz_receive_clock;
  hpf_host_port #(.STRETCH_CYC(STR)) DUT (.*);
  hpf_mem_model PM (.pclk(pclk), .clock(serial_mem_clock), .select(serial_mem_select),
    .din(serial_mem_out), .dout(serial_mem_in), .seen(mem_seen));
  always #5 pclk = ~pclk;
  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, with no bound of its own
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // host strobe held low; caller checks, then host_end
  task host(input logic w, input logic [15:0] a, input logic q, input logic [15:0] d);
    @(posedge pclk);
    upper_io_address_bits <= a[15:4];
    address_qualifier <= q;
    io_data_in <= d;
    @(posedge pclk);
    if (w) io_write_strobe_n <= 1'b0;
    else io_read_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task host_end;
    @(posedge pclk);
    io_read_strobe_n <= 1'b1;
    io_write_strobe_n <= 1'b1;
    address_qualifier <= 1'b1;
  endtask
  task do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int n;
    {presetn, psel, penable, pwrite, paddr, pwdata, irq_request, io_data_in} = '0;
    {io_read_strobe_n, io_write_strobe_n, rom_read_strobe_n, address_qualifier} = 4'hf;
    {upper_io_address_bits, tx_active, rx_active, link_ok, nrz_tx_data} = '0;
    {codec_rxd, codec_nrz_receive_clock, config_switch_low_pair, config_switch_high} = 5'h05;
    {external_codec_strap_n, wide_bus_strap_n} = 2'h3;
    do_reset;
    apb(0, 32'h20, 0);
    check(rd, 32'h06);
    apb(0, 32'h04, 0);
    check(rd, 32'h0300);
    apb(0, 32'h24, 0);
    check(err, 1'b1);
    irq_request <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1, 32'h00, i);
      repeat (2) @(posedge pclk);
      check({irq_oe, irq_out}, {4'h1 << i, 4'h1 << i});
    end
    irq_request <= 1'b0;
    repeat (2) @(posedge pclk);
    check(irq_out, 4'h0);
    apb(1, 32'h04, 32'h0350);
    host(1, 16'h0350, 1'b0, 16'hbeef);
    host_end;
    apb(0, 32'h0c, 0);
    check(rd, 32'h8005beef);
    apb(1, 32'h0c, 32'h80000000);
    host(1, 16'h0350, 1'b1, 16'h1111);
    host_end;
    apb(0, 32'h0c, 0);
    check(rd, 32'h0005beef);
    apb(1, 32'h04, 32'h0300);
    apb(1, 32'h08, 32'h1234);
    host(0, 16'h0300, 1'b0, 16'h0);
    check({io_data_oe, io_data_out}, 17'h11234);
    check({bsel_pin_oe, bsel_pin_out, wide_io_ack_n_oe}, 3'h4);
    host_end;
    repeat (10) @(posedge pclk);
    check(bsel_pin_oe, 1'b1);
    repeat (STR) @(posedge pclk);
    check(bsel_pin_oe, 1'b0);
    apb(1, 32'h00, 32'h4);
    host(0, 16'h0300, 1'b0, 16'h0);
    check(wide_io_ack_n_oe, 1'b1);
    host_end;
    host(0, 16'h0400, 1'b0, 16'h0);
    check({wide_io_ack_n_oe, io_data_oe}, 2'h0);
    host_end;
    @(posedge pclk);
    rom_read_strobe_n <= 1'b0;
    address_qualifier <= 1'b0;
    repeat (2) @(posedge pclk);
    check(rom_select_n, 1'b0);
    address_qualifier <= 1'b1;
    repeat (2) @(posedge pclk);
    check(rom_select_n, 1'b1);
    rom_read_strobe_n <= 1'b1;
    {tx_active, rx_active, link_ok} <= 3'h7;
    repeat (2) @(posedge pclk);
    check({tx_pin_oe, tx_pin_out, rx_pin_oe, rx_pin_out, link_pin_oe, link_pin_out},
      6'h2a);
    {tx_active, rx_active, link_ok} <= 3'h0;
    apb(1, 32'h14, 32'h3c);
    apb(1, 32'h10, 32'h80000007);
    for (n = 0; n < 100; n++) begin
      apb(0, 32'h18, 0);
      if (rd[1] === 1'b1) break;
      repeat (50) @(posedge pclk);
    end
    check(rd[1], 1'b1);
    apb(0, 32'h1c, 0);
    check(rd[7:0], 8'ha5);
    check(mem_seen, 8'h3c);
    apb(1, 32'h18, 32'h2);
    apb(0, 32'h18, 0);
    check(rd, 32'h0);
    external_codec_strap_n <= 1'b0;
    do_reset;
    apb(0, 32'h20, 0);
    check({external_codec, rd[3]}, 2'h3);
    for (int v = 0; v < 2; v++) begin
      b = v[0];
      {tx_active, nrz_tx_data, codec_rxd, codec_nrz_receive_clock} <= {b, b, b, ~b};
      repeat (3) @(posedge pclk);
      check({tx_pin_oe, tx_pin_out}, {1'b1, ~b});
      check({link_pin_oe, link_pin_out}, {1'b1, b});
      check({bsel_pin_oe, nrz_rx_data}, {1'b0, b});
      check({rx_pin_oe, nrz_receive_clock}, {1'b0, ~b});
    end
    report_and_stop;
  end
  // watchdog, well beyond the serial exchange
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    report_and_stop;
  end
endmodule // tb_top
